// >>> src/fuse_syscall_regs.svh
// constants for the fuse margin read and tool response system calls
// Function
// - opcode 0x2B in bits 31:24 asks for one fuse byte read under a margin.
// - a blown fuse bit reads as one and an unblown bit as zero.
// - margin field 23:20 picks low (0), nominal (1), high (2) or full (other) resistance.
// - the fuse byte address 0 to 511 sits in bits 19:8 and that byte is read.
// - bit 0 set means every argument comes straight from the data word.
// - the status nibble 31:28 is 0xA on success and 0xF on error.
// - a debug-port call gets the fuse byte back in bits 7:0 of the data word, bits 27:8 zero.
// - a processor call gets the return word written over the command word at the address in the data word.
// - opcode 0x32 sets or clears the tool response word, bits 23:16 are zero.
// - the response state is stored in the second word of the public RAM region.
// - bits 15:8 zero clear the response, 1 to 255 set it, bits 7:0 hold 0x01.
// - the response command returns the status nibble with an error code on failure.
`ifndef FUSE_SYSCALL_REGS_SVH
`define FUSE_SYSCALL_REGS_SVH
`define OP_MARGIN_READ 8'h2B
`define OP_TOOL_RESP 8'h32
`define STAT_OK 4'hA
`define STAT_ERR 4'hF
`define FUSE_ADDR_MAX 12'h1FF
`define ERR_BAD_OPCODE 28'h0000001
`define ERR_BAD_ADDR 28'h0000002
`define ERR_BAD_ARGS 28'h0000003
`define ERR_MISALIGNED 28'h0000004
`define PUB_RESP_ADDR 32'h00000004
`define RESP_SET_VALUE 32'h00000001
`define RESP_CLR_VALUE 32'h00000000
`define DATA_WORD_RESET 32'h00000000
`endif

// >>> src/fuse_syscall_pkg.sv
// types for the fuse margin read and tool response system calls
package fuse_syscall_pkg;
	typedef enum logic [1:0] {
		margin_low,
		margin_nominal,
		margin_high,
		margin_full
	} margin_e;
	typedef struct packed {
		logic req;
		logic [8:0] addr;
		margin_e margin;
	} fuse_req_s;
	typedef struct packed {
		logic req;
		logic wr;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_req_s;
endpackage

// >>> src/fuse_margin_read_syscall.sv
// system call decoder for margin fuse reads and the tool response word
`timescale 1ns/10ps
`default_nettype none
`include "fuse_syscall_regs.svh"
module fuse_margin_read_syscall (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic data_wr,
	input wire logic [31:0] data_wdata,
	output logic [31:0] syscall_data_word,
	output logic busy,
	output logic done,
	output fuse_syscall_pkg::fuse_req_s fuse_req,
	input wire logic fuse_ack,
	input wire logic [7:0] fuse_bits,
	output fuse_syscall_pkg::mem_req_s mem_req,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata
);
	import fuse_syscall_pkg::*;
	typedef enum logic [2:0] {
		st_idle,
		st_fetch,
		st_exec,
		st_fuse,
		st_resp,
		st_ret
	} state_e;
	state_e state_r, state_nxt;
	logic dbg_r;
	logic [31:0] cmd_r;
	logic [31:0] ptr_r;
	logic [31:0] ret_r;
	wire [7:0] op = cmd_r[31:24];
	wire [3:0] mfield = cmd_r[23:20];
	wire [11:0] faddr = cmd_r[19:8];
	wire margin_e msel = (mfield == 4'h0) ? margin_low :
		(mfield == 4'h1) ? margin_nominal :
		(mfield == 4'h2) ? margin_high : margin_full;
	wire is_read = (op == `OP_MARGIN_READ);
	wire is_resp = (op == `OP_TOOL_RESP);
	wire addr_ok = (faddr <= `FUSE_ADDR_MAX);
	wire resp_args_ok = (cmd_r[23:16] == 8'h00) && (cmd_r[7:0] == 8'h01);
	wire resp_set = (cmd_r[15:8] != 8'h00);
	wire [31:0] err_word = !(is_read || is_resp) ? {`STAT_ERR, `ERR_BAD_OPCODE} :
		(is_read && !addr_ok) ? {`STAT_ERR, `ERR_BAD_ADDR} : {`STAT_ERR, `ERR_BAD_ARGS};
	wire cmd_ok = (is_read && addr_ok) || (is_resp && resp_args_ok);
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			st_idle: if (data_wr) state_nxt = data_wdata[0] ? st_exec : st_fetch;
			st_fetch: if (ptr_r[1:0] != 2'b00) state_nxt = st_idle;
				else if (mem_ack) state_nxt = st_exec;
			st_exec: if (!cmd_ok) state_nxt = dbg_r ? st_idle : st_ret;
				else state_nxt = is_read ? st_fuse : st_resp;
			st_fuse: if (fuse_ack) state_nxt = dbg_r ? st_idle : st_ret;
			st_resp: if (mem_ack) state_nxt = dbg_r ? st_idle : st_ret;
			st_ret: if (mem_ack) state_nxt = st_idle;
			default: state_nxt = st_idle;
		endcase
	end
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_r <= st_idle;
			dbg_r <= 1'b0;
			cmd_r <= `DATA_WORD_RESET;
			ptr_r <= `DATA_WORD_RESET;
			ret_r <= `DATA_WORD_RESET;
			syscall_data_word <= `DATA_WORD_RESET;
			busy <= 1'b0;
			done <= 1'b0;
			fuse_req <= '0;
			mem_req <= '0;
		end else begin
			state_r <= state_nxt;
			done <= 1'b0;
			fuse_req <= '0;
			mem_req <= '0;
			case (state_r)
				st_idle: if (data_wr) begin
					busy <= 1'b1;
					dbg_r <= data_wdata[0];
					cmd_r <= data_wdata;
					ptr_r <= data_wdata;
					syscall_data_word <= data_wdata;
				end
				st_fetch: if (ptr_r[1:0] != 2'b00) begin
					syscall_data_word <= {`STAT_ERR, `ERR_MISALIGNED};
					busy <= 1'b0;
					done <= 1'b1;
				end else if (mem_ack) begin
					cmd_r <= mem_rdata;
				end else begin
					mem_req <= '{req: 1'b1, wr: 1'b0, addr: ptr_r, wdata: 32'h00000000};
				end
				st_exec: if (!cmd_ok) begin
					ret_r <= err_word;
					if (dbg_r) begin
						syscall_data_word <= err_word;
						busy <= 1'b0;
						done <= 1'b1;
					end
				end
				st_fuse: if (fuse_ack) begin
					ret_r <= {`STAT_OK, 20'h00000, fuse_bits};
					if (dbg_r) begin
						syscall_data_word <= {`STAT_OK, 20'h00000, fuse_bits};
						busy <= 1'b0;
						done <= 1'b1;
					end
				end else begin
					fuse_req <= '{req: 1'b1, addr: faddr[8:0], margin: msel};
				end
				st_resp: if (mem_ack) begin
					ret_r <= {`STAT_OK, 28'h0000000};
					if (dbg_r) begin
						syscall_data_word <= {`STAT_OK, 28'h0000000};
						busy <= 1'b0;
						done <= 1'b1;
					end
				end else begin
					mem_req <= '{req: 1'b1, wr: 1'b1, addr: `PUB_RESP_ADDR,
						wdata: resp_set ? `RESP_SET_VALUE : `RESP_CLR_VALUE};
				end
				st_ret: if (mem_ack) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					mem_req <= '{req: 1'b1, wr: 1'b1, addr: ptr_r, wdata: ret_r};
				end
				default: ;
			endcase
		end
	end
	property p_status_nibble;
		@(posedge clk_sys) disable iff (reset)
		done |-> (syscall_data_word[31:28] == `STAT_OK || syscall_data_word[31:28] == `STAT_ERR
			|| !dbg_r);
	endproperty
	a_status_nibble: assert property (p_status_nibble) else $error("bad status nibble");
	property p_fuse_return;
		@(posedge clk_sys) disable iff (reset)
		(state_r == st_fuse && fuse_ack && dbg_r) |=>
			(syscall_data_word == {4'hA, 20'h00000, $past(fuse_bits)}) && done;
	endproperty
	a_fuse_return: assert property (p_fuse_return) else $error("fuse byte not returned");
	property p_bad_op;
		@(posedge clk_sys) disable iff (reset)
		(state_r == st_exec && !is_read && !is_resp) |=> !fuse_req.req && ret_r[31:28] == 4'hF;
	endproperty
	a_bad_op: assert property (p_bad_op) else $error("bad opcode accepted");
	property p_addr_range;
		@(posedge clk_sys) disable iff (reset)
		fuse_req.req |-> $past(is_read) && $past(faddr) <= 12'h1FF;
	endproperty
	a_addr_range: assert property (p_addr_range) else $error("fuse request out of range");
	property p_resp_addr;
		@(posedge clk_sys) disable iff (reset)
		(mem_req.req && state_r == st_resp) |-> mem_req.wr && mem_req.addr == 32'h00000004
			&& mem_req.wdata == {31'h0, $past(cmd_r[15:8]) != 8'h00};
	endproperty
	a_resp_addr: assert property (p_resp_addr) else $error("response word write wrong");
	property p_cpu_return;
		@(posedge clk_sys) disable iff (reset)
		(mem_req.req && state_r == st_ret) |-> mem_req.wr && mem_req.addr == ptr_r;
	endproperty
	a_cpu_return: assert property (p_cpu_return) else $error("return word misplaced");
	property p_dbg_direct;
		@(posedge clk_sys) disable iff (reset)
		(state_r == st_idle && data_wr && data_wdata[0]) |=> state_r == st_exec;
	endproperty
	a_dbg_direct: assert property (p_dbg_direct) else $error("debug call fetched");
	property p_margin;
		@(posedge clk_sys) disable iff (reset)
		(fuse_req.req && $past(mfield) == 4'h1) |-> fuse_req.margin == margin_nominal;
	endproperty
	a_margin: assert property (p_margin) else $error("margin decode wrong");
	property p_margin_low;
		@(posedge clk_sys) disable iff (reset)
		(fuse_req.req && $past(mfield) == 4'h0) |-> fuse_req.margin == margin_low;
	endproperty
	a_margin_low: assert property (p_margin_low) else $error("low margin decode wrong");
	property p_margin_high;
		@(posedge clk_sys) disable iff (reset)
		(fuse_req.req && $past(mfield) == 4'h2) |-> fuse_req.margin == margin_high;
	endproperty
	a_margin_high: assert property (p_margin_high) else $error("high margin decode wrong");
	property p_margin_full;
		@(posedge clk_sys) disable iff (reset)
		(fuse_req.req && $past(mfield) > 4'h2) |-> fuse_req.margin == margin_full;
	endproperty
	a_margin_full: assert property (p_margin_full) else $error("full margin decode wrong");
	property p_fuse_hold;
		@(posedge clk_sys) disable iff (reset)
		(fuse_req.req && !fuse_ack) |=> fuse_req.req && $stable(fuse_req);
	endproperty
	a_fuse_hold: assert property (p_fuse_hold) else $error("fuse request dropped");
	property p_mem_hold;
		@(posedge clk_sys) disable iff (reset)
		(mem_req.req && !mem_ack) |=> mem_req.req && $stable(mem_req);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped");
	property p_done_idle;
		@(posedge clk_sys) disable iff (reset)
		done |-> !busy && state_r == st_idle;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("done while still busy");
	property p_resp_status;
		@(posedge clk_sys) disable iff (reset)
		(state_r == st_resp && mem_ack && dbg_r) |=>
			syscall_data_word == {`STAT_OK, 28'h0000000} && done;
	endproperty
	a_resp_status: assert property (p_resp_status) else $error("response status missing");
	property p_err_status;
		@(posedge clk_sys) disable iff (reset)
		(state_r == st_exec && !cmd_ok && dbg_r) |=>
			done && syscall_data_word[31:28] == `STAT_ERR;
	endproperty
	a_err_status: assert property (p_err_status) else $error("error status missing");
	property p_misaligned;
		@(posedge clk_sys) disable iff (reset)
		(state_r == st_fetch && ptr_r[1:0] != 2'b00) |=>
			done && !mem_req.req && syscall_data_word[31:28] == `STAT_ERR;
	endproperty
	a_misaligned: assert property (p_misaligned) else $error("misaligned pointer fetched");
	property p_keep_ptr;
		@(posedge clk_sys) disable iff (reset)
		(state_r == st_ret) |-> syscall_data_word == ptr_r;
	endproperty
	a_keep_ptr: assert property (p_keep_ptr) else $error("pointer overwritten");
endmodule
`default_nettype wire

// >>> bench/fuse_far_model.sv
// far side model: fuse array and sram
`timescale 1ns/10ps
`default_nettype none
module fuse_far_model (
	input wire logic clk_sys,
	input wire logic reset,
	input wire fuse_syscall_pkg::fuse_req_s fuse_req,
	output logic fuse_ack,
	output logic [7:0] fuse_bits,
	input wire fuse_syscall_pkg::mem_req_s mem_req,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [31:0] ram [0:15];
	logic [1:0] dly_r;
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			{fuse_ack, mem_ack, dly_r, fuse_bits, mem_rdata} <= '0;
		end else begin
			{fuse_ack, mem_ack} <= 2'h0;
			dly_r <= dly_r + 2'h1;
			fuse_bits <= ~fuse_bits;
			mem_rdata <= ~mem_rdata;
			if (fuse_req.req && !fuse_ack && dly_r == 2'h0) begin
				fuse_ack <= 1'b1;
				fuse_bits <= fuse_req.addr[7:0] ^ {fuse_req.margin, fuse_req.addr[8], 5'h0};
			end
			if (mem_req.req && !mem_ack && dly_r[0]) begin
				mem_ack <= 1'b1;
				mem_rdata <= ram[mem_req.addr[5:2]];
				if (mem_req.wr) ram[mem_req.addr[5:2]] <= mem_req.wdata;
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/tb_fuse_margin_read_syscall.sv
// self-checking bench for the fuse system call block
`timescale 1ns/10ps
`default_nettype none
module tb_fuse_margin_read_syscall;
	import fuse_syscall_pkg::*;
	logic clk_sys, reset, data_wr, busy, done, fuse_ack, mem_ack;
	logic [31:0] data_wdata, syscall_data_word, mem_rdata, w;
	logic [7:0] fuse_bits;
	fuse_req_s fuse_req;
	mem_req_s mem_req;
	int err_total, compares, seed, i;
	fuse_margin_read_syscall fuse_margin_read_syscall_inst (.clk_sys(clk_sys), .reset(reset),
		.data_wr(data_wr), .data_wdata(data_wdata), .syscall_data_word(syscall_data_word),
		.busy(busy), .done(done), .fuse_req(fuse_req), .fuse_ack(fuse_ack),
		.fuse_bits(fuse_bits), .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	fuse_far_model fuse_far_model_inst (.clk_sys(clk_sys), .reset(reset), .fuse_req(fuse_req),
		.fuse_ack(fuse_ack), .fuse_bits(fuse_bits), .mem_req(mem_req), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	function automatic logic [31:0] exp_ret(input logic [31:0] c);
		logic [11:0] a;
		logic [1:0] m;
		a = c[19:8];
		m = (c[23:20] > 4'h2) ? 2'h3 : c[21:20];
		if (c[31:24] == 8'h2B) begin
			if (a > 12'h1FF) return {4'hF, 28'h2};
			return {4'hA, 20'h0, a[7:0] ^ {m, a[8], 5'h0}};
		end
		if (c[31:24] == 8'h32) begin
			if (c[23:16] != 8'h00 || c[7:0] != 8'h01) return {4'hF, 28'h3};
			return {4'hA, 28'h0};
		end
		return {4'hF, 28'h1};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic call(input logic [31:0] c);
		int n;
		n = 0;
		@(negedge clk_sys);
		data_wr = 1'b1;
		data_wdata = c;
		@(negedge clk_sys);
		chk({31'h0, busy}, 32'h00000001);
		while (done !== 1'b1 && n < 100) begin
			data_wr = (n == 1);
			data_wdata = ~c;
			@(negedge clk_sys);
			n++;
		end
		data_wr = 1'b0;
		chk({31'h0, busy}, 32'h00000000);
		if (done !== 1'b1) err_total++;
	endtask
	task automatic run(input logic [31:0] c, input logic cpu, input logic [31:0] p);
		logic [31:0] e;
		e = exp_ret(c);
		if (cpu) begin
			fuse_far_model_inst.ram[p[5:2]] = c;
			call(p);
			chk(fuse_far_model_inst.ram[p[5:2]], e);
			chk(syscall_data_word, p);
		end else begin
			call(c);
			chk(syscall_data_word, e);
		end
		if (c[31:24] == 8'h32 && e[31:28] == 4'hA)
			chk(fuse_far_model_inst.ram[1], {31'h0, c[15:8] != 8'h00});
		$display("test %h done", c);
	endtask
	task end_of_test;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#800000;
		err_total++;
		end_of_test;
	end
	initial begin
		seed = 21499;
		{err_total, compares} = '0;
		{reset, data_wr, data_wdata} = {1'b1, 33'h0};
		repeat (5) @(negedge clk_sys);
		reset = 1'b0;
		for (i = 0; i < 4; i++) begin
			w = {8'h2B, (i == 3) ? 4'hF : i[3:0], 12'h1FF, 8'h01};
			run(w, i[0], 32'h20 + 32'(i * 4));
		end
		run(32'h2B120001, 1'b0, 32'h0);
		run(32'h32000101, 1'b0, 32'h0);
		run(32'h32000001, 1'b0, 32'h0);
		run(32'h32FF0101, 1'b0, 32'h0);
		run(32'h32000103, 1'b0, 32'h0);
		run(32'h55000001, 1'b0, 32'h0);
		run(32'h3200FF01, 1'b1, 32'h3C);
		call(32'h22);
		chk(syscall_data_word, {4'hF, 28'h4});
		$display("test misaligned pointer done");
		for (i = 0; i < 40; i++) begin
			w = $random(seed);
			if (w[29]) w = {8'h32, 8'h00, w[15:8], 8'h01};
			else w = {8'h2B, w[23:20], w[31] ? w[19:8] : {3'h0, w[16:8]}, 8'h01};
			run(w, w[30], {26'h0, 1'b1, w[4:2], 2'h0});
		end
		end_of_test;
	end
endmodule
`default_nettype wire
